/* File: rtl/dwl_defs.vh */
// Constants for the write-leveling block: mode register one fields, register offsets, timing counts.
// Assumes a 100 MHz system clock and a Wishbone register port.
`ifndef DWL_DEFS_VH
`define DWL_DEFS_VH
`define DWL_MR1_BIT_A1 1
`define DWL_MR1_BIT_A2 2
`define DWL_MR1_BIT_A5 5
`define DWL_MR1_BIT_A6 6
`define DWL_MR1_BIT_A7 7
`define DWL_MR1_BIT_A9 9
`define DWL_MR1_BIT_A12 12
`define DWL_MR1_RESET 16'h0000
`define DWL_MR1_KEEP_MASK 16'h1266
`define DWL_ADDR_MR1 4'h0
`define DWL_ADDR_CMD 4'h4
`define DWL_ADDR_STATUS 4'h8
`define DWL_ADDR_SAMPLE 4'hC
`define DWL_CMD_NOP 2'h0
`define DWL_CMD_MRS1 2'h1
`define DWL_CMD_OTHER 2'h2
`define DWL_CLK_MHZ 100
`define DWL_TWLO_NS 8
`define DWL_TWLO_CYC ((`DWL_TWLO_NS * `DWL_CLK_MHZ) / 1000)
`define DWL_TMOD_CYC 12
`define DWL_TWLDQSEN_CYC 25
`endif

/* File: rtl/dwl_sync.v */
// Two flip-flop synchroniser for a bus of asynchronous levels.
// Assumes inputs are levels from outside the clk_i domain.
`timescale 1ns/1ps
module dwl_sync #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

/* File: rtl/dwl_top.v */
// Write-leveling logic of a x16 DRAM with mode register one reachable over Wishbone.
// Assumes pins ck, odt and the strobe pairs are asynchronous to clk_i; the testbench checks dq_o and dq_oe_n_o as separate outputs.
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dwl_defs.vh"
module dwl_top #(
  parameter ALL_BITS_FEEDBACK = 1'b0,
  parameter TMOD_CYC = `DWL_TMOD_CYC,
  parameter TWLDQSEN_CYC = `DWL_TWLDQSEN_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ck_i,
  input wire odt_i,
  input wire upper_lane_strobe_pair_i,
  input wire lower_lane_strobe_pair_i,
  output reg [15:0] dq_o,
  output reg [15:0] dq_oe_n_o,
  output reg dq_undefined_o,
  output reg strobe_term_on_o,
  output reg dq_term_on_o,
  output reg read_strobe_drive_o,
  output reg leveling_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_LEVEL = 2'h2;
  localparam TWLO_C = (`DWL_TWLO_CYC < 1) ? 1 : `DWL_TWLO_CYC;

  wire [3:0] pins_s;
  reg [15:0] mr1;
  reg [1:0] state;
  reg [15:0] wait_cnt;
  reg odt_ok;
  reg term_ok;
  reg [1:0] strobe_d;
  reg [1:0] sample;
  reg [1:0] sampled_once;
  reg [3:0] fb_cnt;
  reg [15:0] mrs_count;
  reg [1:0] cmd_err;
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & (&wb_sel_i[1:0]);
  wire mr1_wr = bus_wr & (wb_adr_i[3:0] == `DWL_ADDR_MR1);
  wire cmd_wr = bus_wr & (wb_adr_i[3:0] == `DWL_ADDR_CMD);
  wire lvl = mr1[`DWL_MR1_BIT_A7];
  wire qoff = mr1[`DWL_MR1_BIT_A12];
  wire [15:0] mr1_new = wb_dat_i[15:0];
  wire exit_wr = lvl & ~mr1_new[`DWL_MR1_BIT_A7];
  // During leveling a non-exit write may only change A12; otherwise the write is flagged and dropped
  wire mr1_legal = ~lvl | exit_wr |
    ((mr1_new & ~(16'h1000)) == (mr1 & ~(16'h1000)));
  wire [1:0] rise = pins_s[3:2] & ~strobe_d;

  dwl_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({upper_lane_strobe_pair_i, lower_lane_strobe_pair_i, odt_i, ck_i}),
    .sync_o(pins_s)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      mr1 <= `DWL_MR1_RESET;
      cmd_err <= 2'h0;
      mrs_count <= 16'h0000;
    end else begin
      if (mr1_wr && mr1_legal) begin
        mr1 <= mr1_new;
        mrs_count <= mrs_count + 16'h0001;
      end
      if (mr1_wr && !mr1_legal) begin
        cmd_err[0] <= 1'b1;
      end
      // Commands other than NOP during leveling are illegal for the controller; only the OTHER command code is flagged here
      if (cmd_wr && lvl && wb_dat_i[1:0] == `DWL_CMD_OTHER) begin
        cmd_err[1] <= 1'b1;
      end else if (bus_wr && wb_adr_i[3:0] == `DWL_ADDR_STATUS && wb_dat_i[8]) begin
        cmd_err <= 2'h0;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i[3:0])
          `DWL_ADDR_MR1: wb_dat_o <= {16'h0000, mr1};
          `DWL_ADDR_STATUS: wb_dat_o <= {16'h0000, mrs_count[3:0], 2'h0, cmd_err, 2'h0, odt_ok, term_ok,
            2'h0, state};
          `DWL_ADDR_SAMPLE: wb_dat_o <= {28'h0000000, sampled_once, sample};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      wait_cnt <= 16'h0000;
      odt_ok <= 1'b0;
      term_ok <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          odt_ok <= 1'b0;
          term_ok <= 1'b0;
          wait_cnt <= 16'h0000;
          if (lvl) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT, ST_LEVEL: begin
          if (!lvl) begin
            state <= ST_IDLE;
          end else begin
            if (wait_cnt != 16'hFFFF) begin
              wait_cnt <= wait_cnt + 16'h0001;
            end
            if (wait_cnt + 16'h0001 >= TMOD_CYC[15:0]) begin
              odt_ok <= 1'b1;
            end
            if (odt_ok && pins_s[1] && wait_cnt + 16'h0001 >= TWLDQSEN_CYC[15:0]) begin
              term_ok <= 1'b1;
              state <= ST_LEVEL;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      always @(posedge clk_i) begin
        if (rst_i) begin
          strobe_d[g] <= 1'b0;
          sample[g] <= 1'b0;
          sampled_once[g] <= 1'b0;
        end else begin
          strobe_d[g] <= pins_s[2+g];
          if (!lvl) begin
            sampled_once[g] <= 1'b0;
          end else if (rise[g] && state == ST_LEVEL) begin
            sample[g] <= pins_s[0];
            sampled_once[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      fb_cnt <= 4'h0;
    end else if (|rise) begin
      fb_cnt <= 4'h0;
    end else if (fb_cnt != 4'hF) begin
      fb_cnt <= fb_cnt + 4'h1;
    end
  end

  // Both lanes share one CK sample path, so lane skew stays within a cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      dq_o <= 16'h0000;
      dq_oe_n_o <= 16'hFFFF;
      dq_undefined_o <= 1'b0;
      strobe_term_on_o <= 1'b0;
      dq_term_on_o <= 1'b0;
      read_strobe_drive_o <= 1'b0;
      leveling_o <= 1'b0;
    end else begin
      leveling_o <= lvl;
      read_strobe_drive_o <= 1'b0;
      strobe_term_on_o <= lvl & term_ok & pins_s[1];
      dq_term_on_o <= 1'b0;
      dq_undefined_o <= lvl & ~qoff & ~(|sampled_once);
      if (!lvl || qoff) begin
        dq_oe_n_o <= 16'hFFFF;
        dq_o <= 16'h0000;
      end else begin
        dq_oe_n_o <= 16'h0000;
        if (fb_cnt + 4'h1 >= TWLO_C[3:0] || (|sampled_once)) begin
          // Prime bits are DQ0 and DQ8; remaining bits low once sampling has begun, or copies of the lane's prime bit with ALL_BITS_FEEDBACK
          dq_o[0] <= sample[0];
          dq_o[8] <= sample[1];
          dq_o[7:1] <= ALL_BITS_FEEDBACK ? {7{sample[0]}} : 7'h00;
          dq_o[15:9] <= ALL_BITS_FEEDBACK ? {7{sample[1]}} : 7'h00;
        end
      end
    end
  end
endmodule

/* File: sim/dwl_props.sv */
// Checker of the write-leveling block pins.
// Assumes a bind onto dwl_top.
`timescale 1ns/1ps
module dwl_props (
  input wire clk_i,
  input wire rst_i,
  input wire lower_lane_strobe_pair_i,
  input wire [15:0] dq_o,
  input wire [15:0] dq_oe_n_o,
  input wire dq_undefined_o,
  input wire strobe_term_on_o,
  input wire dq_term_on_o,
  input wire read_strobe_drive_o,
  input wire leveling_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_dq_term_off: assert property (!dq_term_on_o) else $error("dq term on");
  a_no_rd_strobe: assert property (!read_strobe_drive_o) else $error("read strobe");
  a_term_in_lvl: assert property (strobe_term_on_o |-> leveling_o) else $error("term idle");
  a_term_late: assert property ($rose(strobe_term_on_o) |-> $past(leveling_o, 20)) else $error("term early");
  a_undef_lvl: assert property (dq_undefined_o |-> leveling_o) else $error("undef idle");
  a_idle_float: assert property (!leveling_o ##1 !leveling_o |-> &dq_oe_n_o) else $error("dq driven");
  a_quiet_bits: assert property (dq_o[7:1] == 7'h00 && dq_o[15:9] == 7'h00) else $error("dq bits");
  // Eight quiet cycles cover the synchroniser and sample pipeline
  a_hold_sample: assert property ((leveling_o && !lower_lane_strobe_pair_i && !dq_oe_n_o[0])[*8] |=>
    $stable(dq_o[0]))
    else $error("sample moved");
endmodule
bind dwl_top dwl_props i_dwl_props(.clk_i(clk_i), .rst_i(rst_i), .lower_lane_strobe_pair_i(lower_lane_strobe_pair_i),
  .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dq_undefined_o(dq_undefined_o), .strobe_term_on_o(strobe_term_on_o),
  .dq_term_on_o(dq_term_on_o), .read_strobe_drive_o(read_strobe_drive_o), .leveling_o(leveling_o));

/* File: sim/dwl_ctrl_model.sv */
// Memory controller model: free CK, ODT, strobes.
// Assumes the bench calls its tasks in order.
`timescale 1ns/1ps
module dwl_ctrl_model;
  logic ck = 0;
  // ODT rests low outside leveling, so no frequency change can see termination on
  logic odt = 0;
  logic [1:0] dqs = 0;
  // CK runs free, out of phase with clk_i
  initial #3 forever #80 ck = ~ck;
  // Strobes rest low once termination is on
  task pulse(input int lane, input int lag);
    @(posedge ck);
    #(lag) dqs[lane] = 1;
    #40 dqs[lane] = 0;
    #200;
  endtask
  task set_odt(input logic v);
    odt = v;
  endtask
endmodule

/* File: sim/dwl_top_test.sv */
// Bench of the write-leveling block.
// Assumes the controller model drives the link pins.
`timescale 1ns/1ps
module dwl_top_test;
  typedef struct {int lane; int lag; logic v;} dwl_row_t;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0, rd;
  logic [15:0] exp_dq = 0;
  wire [31:0] wb_dat_o;
  wire [15:0] dq_o, dq_oe_n_o;
  wire wb_ack_o, dq_undefined_o, strobe_term_on_o, dq_term_on_o, read_strobe_drive_o, leveling_o;
  int failures = 0, num_checks = 0, cyc = 0;
  dwl_row_t rows[5] = '{'{0, 120, 1'b0}, '{0, 40, 1'b1}, '{1, 120, 1'b0}, '{1, 20, 1'b1}, '{0, 100, 1'b0}};
  dwl_ctrl_model i_dwl_ctrl_model();
  dwl_top i_dwl_top(.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ck_i(i_dwl_ctrl_model.ck), .odt_i(i_dwl_ctrl_model.odt), .upper_lane_strobe_pair_i(i_dwl_ctrl_model.dqs[1]),
    .lower_lane_strobe_pair_i(i_dwl_ctrl_model.dqs[0]), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
    .dq_undefined_o(dq_undefined_o), .strobe_term_on_o(strobe_term_on_o), .dq_term_on_o(dq_term_on_o),
    .read_strobe_drive_o(read_strobe_drive_o), .leveling_o(leveling_o));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  // Holds the request until ack is sampled high
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    chk("oe", dq_oe_n_o, 16'hFFFF);
    wb(0, 32'h2, 0);
    chk("unmapped", rd, 0);
    wb(1, 32'h0, 32'h80);
    repeat (2) @(posedge clk_i);
    chk("lvl", leveling_o, 1);
    chk("undef", dq_undefined_o, 1);
    repeat (12) @(posedge clk_i);
    i_dwl_ctrl_model.set_odt(1);
    repeat (30) @(posedge clk_i);
    chk("sterm", strobe_term_on_o, 1);
    chk("dterm", dq_term_on_o, 0);
    $display("entry test done");
    foreach (rows[i]) begin
      i_dwl_ctrl_model.pulse(rows[i].lane, rows[i].lag);
      exp_dq[rows[i].lane * 8] = rows[i].v;
      chk("dq", dq_o, exp_dq);
      chk("def", {dq_undefined_o, dq_oe_n_o}, 0);
    end
    wb(1, 32'h0, 32'h1080);
    repeat (2) @(posedge clk_i);
    chk("qoff", dq_oe_n_o, 16'hFFFF);
    wb(1, 32'h0, 32'h80);
    repeat (2) @(posedge clk_i);
    chk("hold", {dq_oe_n_o, dq_o}, exp_dq);
    wb(1, 32'h4, 32'h2);
    wb(1, 32'h0, 32'h280);
    wb(0, 32'h8, 0);
    chk("err", rd[9:8], 2'h3);
    wb(0, 32'h0, 0);
    chk("kept", rd, 32'h80);
    $display("leveling test done");
    i_dwl_ctrl_model.set_odt(0);
    repeat (8) @(posedge clk_i);
    wb(1, 32'h0, 32'h1266);
    wb(0, 32'h0, 0);
    chk("exit", rd, 32'h1266);
    chk("float", {leveling_o, dq_oe_n_o}, 16'hFFFF);
    $display("exit test done");
    give_verdict();
  end
endmodule
